// >>> hdl/spbc_bridge_cfg.sv
// Function
// (R1) Wheatstone bridge uses topology code 1, as full bridge.
// (R2) Wheatstone mode active only when config word three bit 21 set.
// (R3) Wheatstone needs opposite-sign half gain factors.
// (R4) Wheatstone needs span-resistor modification bit set.
// (R5) Wheatstone with span resistor uses temperature gain 0.75.
// (R6) Quattro is topology 3; per half and combined results given.
// (R7) Quattro applies a separate gain factor per half bridge.
// (R8) Separate half bridges: host computes (A-B)/2 and (C-D)/2.
// (R9) Grounded load line with tap on load pin selects legacy mode.
// (R10) Legacy mode enables only N-channel switch transistors.
// (R11) Legacy only for half, full, quattro; never with Wheatstone.
// (R12) Noise-reduction bit grounds all ports not measured this cycle; code grounds none in legacy mode.
// (R13) Normal mode discharges through selected port's analog switch.
// (R14) Wheatstone bridges with two span resistors are unsupported.
// (R15) Half bridge on A and B uses topology 0, positive factors.
// (R16) Full bridge with two series span resistors sets integrated bit.
// (R17) Topology code 2 is reserved and treated as invalid.
`timescale 1ns/1ps
`default_nettype none
`include "spbc_params.svh"
module spbc_bridge_cfg (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [31:0] i_cfg_three,
	input wire logic [31:0] i_config_word_one,
	input wire logic [31:0] i_cfg_twelve,
	input wire logic signed [7:0] i_half_one_gain_factor,
	input wire logic signed [7:0] i_half_two_gain_factor,
	input wire logic signed [7:0] i_half_three_gain_factor,
	input wire logic signed [7:0] i_half_four_gain_factor,
	input wire logic i_load_line_pin,
	input wire logic i_load_tap_pin,
	input wire logic i_cycle_start,
	input wire logic i_cycle_end,
	output logic o_wheat_mode,
	output logic o_legacy_mode,
	output logic o_cfg_error,
	output logic o_busy,
	output logic [1:0] o_port_sel,
	output logic signed [7:0] o_gain_factor,
	output logic [3:0] o_pch_en,
	output logic [3:0] o_nch_en,
	output logic [3:0] o_gnd_en
);
	spbc_sw_if sw ();
	spbc_pkg::spbc_state_type state_r;
	logic [1:0] topo;
	logic [1:0] line_s_r;
	logic [1:0] tap_s_r;
	logic legacy_r;
	logic wheat_r;
	logic [1:0] sel_r;
	logic [1:0] sel_nxt;
	logic emi_en;

	function automatic logic [1:0] next_port(input logic [1:0] cur, input logic [1:0] tp);
		logic [1:0] n;
		n = cur + 2'h1;
		if (tp == `SPBC_TOPO_HALF && n[1])
			n = 2'h0;
		return n;
	endfunction

	assign topo = i_cfg_three[`SPBC_TOPO_LSB +: 2];
	assign emi_en = i_cfg_twelve[`SPBC_EMI_BIT];

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			line_s_r <= 2'h0;
			tap_s_r <= 2'h0;
		end else begin
			line_s_r <= {line_s_r[0], i_load_line_pin};
			tap_s_r <= {tap_s_r[0], i_load_tap_pin};
		end
	end

	// legacy wiring: load line low and bridge tap pulls load pin
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			legacy_r <= 1'b0;
		end else begin
			legacy_r <= ~line_s_r[1] & tap_s_r[1]; // R9
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wheat_r <= 1'b0;
		end else begin
			wheat_r <= i_cfg_three[`SPBC_WHEAT_BIT] && topo == `SPBC_TOPO_FULL; // R2
		end
	end

	assign o_wheat_mode = wheat_r;
	assign o_legacy_mode = legacy_r;
	// reserved topology or wheatstone on legacy wiring is flagged
	assign o_cfg_error = (topo == `SPBC_TOPO_RSVD) || (wheat_r && legacy_r); // R11 R17

	always_comb begin
		sel_nxt = sel_r;
		if (state_r == spbc_pkg::SPBC_DISCHARGE && i_cycle_end)
			sel_nxt = next_port(sel_r, topo);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= spbc_pkg::SPBC_IDLE;
			sel_r <= 2'h0;
		end else begin
			sel_r <= sel_nxt;
			case (state_r)
				spbc_pkg::SPBC_IDLE: begin
					if (i_cycle_start && !o_cfg_error)
						state_r <= spbc_pkg::SPBC_DISCHARGE;
				end
				spbc_pkg::SPBC_DISCHARGE: begin
					if (i_cycle_end)
						state_r <= spbc_pkg::SPBC_IDLE;
				end
				default: state_r <= spbc_pkg::SPBC_IDLE;
			endcase
		end
	end

	assign o_busy = state_r == spbc_pkg::SPBC_DISCHARGE;
	assign o_port_sel = sel_r;

	// per-port gain factor; quattro trims each cell separately
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_gain_factor <= 8'sh0;
		end else begin
			case (sel_r)
				2'h0: o_gain_factor <= i_half_one_gain_factor; // R7
				2'h1: o_gain_factor <= i_half_two_gain_factor;
				2'h2: o_gain_factor <= (topo == `SPBC_TOPO_QUATTRO) ?
					i_half_three_gain_factor : i_half_one_gain_factor; // R7 R6
				default: o_gain_factor <= (topo == `SPBC_TOPO_QUATTRO) ?
					i_half_four_gain_factor : i_half_two_gain_factor; // R7 R6
			endcase
		end
	end

	always_comb begin
		sw.port_on = 4'h0;
		if (o_busy)
			sw.port_on[sel_r] = 1'b1; // R13
		sw.nch_only = legacy_r ? 4'hf : 4'h0; // R10
		sw.port_gnd = (emi_en && !legacy_r && o_busy) ? 4'hf : 4'h0; // R12
	end

	spbc_switch_drv u_drv (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.sw(sw.drv),
		.o_pch_en(o_pch_en),
		.o_nch_en(o_nch_en),
		.o_gnd_en(o_gnd_en)
	);

	// switch enables are registered, so checks look one edge later
	legacy_nch_a: assert property (@(posedge i_clk) disable iff (i_rst) // R10
		legacy_r |=> (o_pch_en == 4'h0))
		else $error("p-channel on in legacy mode");
	legacy_nch_on_a: assert property (@(posedge i_clk) disable iff (i_rst) // R10
		(legacy_r && o_busy) |=> (o_nch_en != 4'h0))
		else $error("no n-channel path in legacy mode");
	wheat_bit_a: assert property (@(posedge i_clk) disable iff (i_rst) // R2
		!$past(i_cfg_three[`SPBC_WHEAT_BIT]) |-> !wheat_r)
		else $error("wheatstone without enable");
	wheat_set_a: assert property (@(posedge i_clk) disable iff (i_rst) // R2
		(i_cfg_three[`SPBC_WHEAT_BIT] && topo == `SPBC_TOPO_FULL) |=> o_wheat_mode)
		else $error("wheatstone enable ignored");
	emi_ground_a: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(emi_en && !legacy_r && o_busy) ##1 (emi_en && !legacy_r)
		|-> (o_gnd_en | o_nch_en) == 4'hf)
		else $error("unused port not grounded");
	emi_off_a: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(!emi_en || legacy_r) |=> (o_gnd_en == 4'h0))
		else $error("port grounded without noise reduction");
	gnd_measured_a: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(o_gnd_en & o_nch_en) == 4'h0)
		else $error("measured port grounded");
	sel_route_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
		o_busy |=> o_nch_en[$past(sel_r)])
		else $error("selected port not switched");
	one_port_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
		$onehot0(o_nch_en))
		else $error("more than one port switched");
	normal_switch_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
		(!legacy_r && o_busy) |=> (o_pch_en == o_nch_en))
		else $error("analog switch incomplete in normal mode");
	idle_open_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
		!o_busy |=> ((o_nch_en | o_pch_en) == 4'h0))
		else $error("port switched while idle");
	start_taken_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
		(!o_busy && i_cycle_start && !o_cfg_error) |=> o_busy)
		else $error("cycle start not taken");
	cycle_end_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
		(o_busy && i_cycle_end) |=> !o_busy)
		else $error("cycle end not taken");
	half_wrap_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
		(o_busy && i_cycle_end && topo == `SPBC_TOPO_HALF) |=> !o_port_sel[1])
		else $error("half bridge left ports a and b");
	// pins reach legacy_r two sync stages and one register late
	legacy_detect_a: assert property (@(posedge i_clk) disable iff (i_rst) // R9
		(!i_load_line_pin && i_load_tap_pin) [*3] |=> legacy_r)
		else $error("legacy wiring missed");
	// reserved topology and legacy wheatstone refuse new cycles
	reserved_topo_a: assert property (@(posedge i_clk) disable iff (i_rst) // R17
		(topo == `SPBC_TOPO_RSVD && !o_busy) |=> !o_busy)
		else $error("reserved topology ran");
	legacy_wheat_a: assert property (@(posedge i_clk) disable iff (i_rst) // R11
		(wheat_r && legacy_r && !o_busy) |=> !o_busy)
		else $error("wheatstone on legacy");
	gain_one_a: assert property (@(posedge i_clk) disable iff (i_rst) // R7
		(sel_r == 2'h0) |=> (o_gain_factor == $past(i_half_one_gain_factor)))
		else $error("gain one wrong");
	quattro_gain_a: assert property (@(posedge i_clk) disable iff (i_rst) // R7
		(topo == `SPBC_TOPO_QUATTRO && $stable(topo) && sel_r == 2'h3)
		|=> o_gain_factor == $past(i_half_four_gain_factor))
		else $error("gain four wrong");
endmodule
`default_nettype wire

// >>> hdl/spbc_params.svh
`ifndef SPBC_PARAMS_SVH
`define SPBC_PARAMS_SVH
`define SPBC_TOPO_HALF 2'h0
`define SPBC_TOPO_FULL 2'h1
`define SPBC_TOPO_RSVD 2'h2
`define SPBC_TOPO_QUATTRO 2'h3
`define SPBC_WHEAT_BIT 21
`define SPBC_TOPO_LSB 0
`define SPBC_RSPAN_MOD_BIT 6
`define SPBC_RSPAN_INT_BIT 5
`define SPBC_EMI_BIT 7
`define SPBC_GAIN_W 8
`define SPBC_PORTS 4
`define SPBC_SEL_W 2
`define SPBC_CYC_HALF 3'h2
`define SPBC_CYC_FULL 3'h4
`endif

// >>> hdl/spbc_pkg.sv
package spbc_pkg;
	typedef enum logic [1:0] {
		SPBC_HALF,
		SPBC_FULL,
		SPBC_RESERVED,
		SPBC_QUATTRO
	} spbc_topo_type;
	typedef enum {
		SPBC_IDLE,
		SPBC_DISCHARGE
	} spbc_state_type;
endpackage

// >>> hdl/spbc_sw_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spbc_sw_if;
	logic [3:0] port_on;
	logic [3:0] nch_only;
	logic [3:0] port_gnd;
	modport ctrl (output port_on, output nch_only, output port_gnd);
	modport drv (input port_on, input nch_only, input port_gnd);
endinterface
`default_nettype wire

// >>> hdl/spbc_switch_drv.sv
`timescale 1ns/1ps
`default_nettype none
`include "spbc_params.svh"
module spbc_switch_drv (
	input wire logic i_clk,
	input wire logic i_rst,
	spbc_sw_if.drv sw,
	output logic [3:0] o_pch_en,
	output logic [3:0] o_nch_en,
	output logic [3:0] o_gnd_en
);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pch_en <= 4'h0;
			o_nch_en <= 4'h0;
			o_gnd_en <= 4'h0;
		end else begin
			o_pch_en <= sw.port_on & ~sw.nch_only;
			o_nch_en <= sw.port_on;
			o_gnd_en <= sw.port_gnd & ~sw.port_on;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/spbc_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module spbc_bridge_model (
	input wire logic i_legacy_wiring,
	output logic o_load_line_pin,
	output logic o_load_tap_pin
);
	assign o_load_line_pin = !i_legacy_wiring;
	assign o_load_tap_pin = i_legacy_wiring;
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module testbench;
	logic clk = 0, rst = 1, st = 0, en = 0, leg = 0, line, tap, wm, lm, ce, bz;
	logic [31:0] c3 = 0, c1 = 0, c12 = 0, rs = 32'h8bfb;
	logic signed [7:0] g [4] = '{default: 8'h01};
	logic signed [7:0] gf;
	logic [1:0] sel, tv [3] = '{2'h0, 2'h1, 2'h3};
	logic [3:0] pe, ne, ge;
	int failures = 0, checks = 0, cnt = 0;
	always #25 clk = ~clk;
	spbc_bridge_model model (.i_legacy_wiring(leg), .o_load_line_pin(line),
		.o_load_tap_pin(tap));
	spbc_bridge_cfg dut (.i_clk(clk), .i_rst(rst), .i_cfg_three(c3), .i_config_word_one(c1),
		.i_cfg_twelve(c12), .i_half_one_gain_factor(g[0]), .i_half_two_gain_factor(g[1]),
		.i_half_three_gain_factor(g[2]), .i_half_four_gain_factor(g[3]),
		.i_load_line_pin(line), .i_load_tap_pin(tap), .i_cycle_start(st), .i_cycle_end(en),
		.o_wheat_mode(wm), .o_legacy_mode(lm), .o_cfg_error(ce), .o_busy(bz), .o_port_sel(sel),
		.o_gain_factor(gf), .o_pch_en(pe), .o_nch_en(ne), .o_gnd_en(ge));
	function logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function logic signed [7:0] exp_g(input int p);
		return (c3[1:0] == 2'h3) ? g[p] : g[p % 2];
	endfunction
	task tick();
		@(posedge clk);
		#1;
	endtask
	task report_and_stop();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task run(input int n, input int wrap, input logic lg, input logic emi);
		logic [3:0] oh;
		for (int i = 0; i < n; i++) begin
			oh = 4'h1 << (i % wrap);
			st = 1;
			tick();
			st = 0;
			`CHK("busy", 1'b1, bz)
			tick();
			`CHK("sel", 2'(i % wrap), sel)
			`CHK("nch", oh, ne)
			`CHK("pch", lg ? 4'h0 : oh, pe)
			`CHK("gnd", (emi && !lg) ? ~oh : 4'h0, ge)
			`CHK("gain", exp_g(i % wrap), gf)
			en = 1;
			tick();
			en = 0;
			`CHK("idle", 1'b0, bz)
		end
	endtask
	always @(posedge clk) begin
		cnt++;
		if (cnt == 5000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) tick();
		rst = 0;
		for (int t = 0; t < 6; t++) begin
			foreach (g[j]) begin
				rs = xs(rs);
				g[j] = rs[7:0];
			end
			c1 = rs;
			c1[5] = (tv[t % 3] == 2'h1);
			c12 = {rs[31:8], rs[8], rs[6:0]};
			c3 = {rs[31:22], 1'b0, rs[20:2], tv[t % 3]};
			leg = (t >= 3);
			rst = 1;
			tick();
			rst = 0;
			repeat (4) tick();
			`CHK("legacy", leg, lm)
			`CHK("wheat", 1'b0, wm)
			run(5, (tv[t % 3] == 2'h0) ? 2 : 4, leg, c12[7]);
		end
		c3 = 32'h0020_0001;
		g[0] = 8'h01;
		g[1] = 8'hff;
		repeat (2) tick();
		`CHK("wheat", 1'b1, wm)
		`CHK("cfgerr", 1'b1, ce)
		leg = 0;
		repeat (4) tick();
		`CHK("cfgerr", 1'b0, ce)
		c1 = 32'h0000_0040;
		rst = 1;
		tick();
		rst = 0;
		repeat (2) tick();
		`CHK("wheat", 1'b1, wm)
		run(4, 4, 1'b0, c12[7]);
		c3 = 32'h0020_0000;
		repeat (2) tick();
		`CHK("wheat", 1'b0, wm)
		c3 = 32'h0000_0002;
		tick();
		`CHK("cfgerr", 1'b1, ce)
		st = 1;
		tick();
		st = 0;
		tick();
		`CHK("busy", 1'b0, bz)
		report_and_stop();
	end
endmodule
`default_nettype wire
